// ==== src/seg_bus_defines.svh ====
// constants of the segmented local segment bus transmit port
`ifndef SEG_BUS_DEFINES_SVH
`define SEG_BUS_DEFINES_SVH

`define SEG_WORD_W 128
`define SEG_CHAN_W 11
`define SEG_EMPTY_W 4
`define SEG_EMPTY_LOW_W 3
`define SEG_CFG_W 2
`define SEG_CFG_MAX 2'h3
`define SEG_CHAN_ALL 11'h7FF
`define SEND_BUF_DEPTH 2
`define SEND_FILL_THRESH 2'h1
`define SEND_COUNT_W 2

`endif

// ==== src/seg_bus_pkg.sv ====
// types shared by both ends of the local segment bus
`include "seg_bus_defines.svh"

package seg_bus_pkg;

    // one segment of one bus cycle
    typedef struct packed {
        logic valid;
        logic [`SEG_WORD_W-1:0] word;
        logic [`SEG_CHAN_W-1:0] channel;
        logic first;
        logic last;
        logic bad;
        logic [`SEG_EMPTY_W-1:0] empty_bytes;
        logic force_burst_word;
    } seg_type;

    // segment 0 in [0], segment 1 in [1]
    typedef seg_type [1:0] seg_pair_type;

endpackage

// ==== src/seg_bus_if.sv ====
// interface joining the user end and the device end of the send port
`timescale 1ns/1ps
`default_nettype none
`include "seg_bus_defines.svh"

interface local_segment_bus_if;
    // send segment 0
    logic [`SEG_WORD_W-1:0] send_seg0_word;
    logic [`SEG_CHAN_W-1:0] send_seg0_channel;
    logic send_seg0_valid;
    logic send_seg0_first;
    logic send_seg0_last;
    logic send_seg0_bad;
    logic [`SEG_EMPTY_W-1:0] send_seg0_empty_bytes;
    logic send_seg0_force_burst_word;
    // send segment 1
    logic [`SEG_WORD_W-1:0] send_seg1_word;
    logic [`SEG_CHAN_W-1:0] send_seg1_channel;
    logic send_seg1_valid;
    logic send_seg1_first;
    logic send_seg1_last;
    logic send_seg1_bad;
    logic [`SEG_EMPTY_W-1:0] send_seg1_empty_bytes;
    logic send_seg1_force_burst_word;
    // flow control and configuration
    logic send_ready;
    logic send_overflow;
    logic [`SEG_CFG_W-1:0] send_channel_range_cfg;
    // receive segment 3
    logic [`SEG_WORD_W-1:0] recv_seg3_word;
    logic [`SEG_CHAN_W-1:0] recv_seg3_channel;
    logic recv_seg3_valid;
    logic recv_seg3_first;
    logic recv_seg3_last;
    logic recv_seg3_bad;
    logic [`SEG_EMPTY_W-1:0] recv_seg3_empty_bytes;

    modport dev (
        input send_seg0_word, send_seg0_channel, send_seg0_valid,
        input send_seg0_first, send_seg0_last, send_seg0_bad,
        input send_seg0_empty_bytes, send_seg0_force_burst_word,
        input send_seg1_word, send_seg1_channel, send_seg1_valid,
        input send_seg1_first, send_seg1_last, send_seg1_bad,
        input send_seg1_empty_bytes, send_seg1_force_burst_word,
        input send_channel_range_cfg,
        output send_ready, send_overflow,
        output recv_seg3_word, recv_seg3_channel, recv_seg3_valid,
        output recv_seg3_first, recv_seg3_last, recv_seg3_bad,
        output recv_seg3_empty_bytes
    );

    modport usr (
        output send_seg0_word, send_seg0_channel, send_seg0_valid,
        output send_seg0_first, send_seg0_last, send_seg0_bad,
        output send_seg0_empty_bytes, send_seg0_force_burst_word,
        output send_seg1_word, send_seg1_channel, send_seg1_valid,
        output send_seg1_first, send_seg1_last, send_seg1_bad,
        output send_seg1_empty_bytes, send_seg1_force_burst_word,
        output send_channel_range_cfg,
        input send_ready, send_overflow,
        input recv_seg3_word, recv_seg3_channel, recv_seg3_valid,
        input recv_seg3_first, recv_seg3_last, recv_seg3_bad,
        input recv_seg3_empty_bytes
    );
endinterface // local_segment_bus_if

`default_nettype wire

// ==== src/send_port_user.sv ====
// user end: presents packet beats on the send segments
`timescale 1ns/1ps
`default_nettype none
`include "seg_bus_defines.svh"

module send_port_user
    import seg_bus_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // user beats, [0] older than [1]
    input wire seg_pair_type i_user_beats,
    input wire logic [`SEG_CFG_W-1:0] i_chan_range_cfg,
    output logic o_user_ready,
    // status seen from the device
    output logic o_send_overflow,
    output seg_type o_recv_seg,
    // bus to the device
    local_segment_bus_if.usr bus
);

    typedef struct packed {
        seg_pair_type out;
        logic in_packet;
        logic ovf;
        seg_type recv;
        logic [`SEG_CFG_W-1:0] cfg;
    } user_state_type;

    user_state_type st_q;
    user_state_type st_d;

    // ---------------------------------------------------------------
    // beat packing
    // ---------------------------------------------------------------
    always_comb begin
        seg_pair_type beats;
        logic in_pkt;
        beats = i_user_beats;
        in_pkt = st_q.in_packet;
        st_d = st_q;
        // lone beat in slot 1 moves down to segment 0
        if (!beats[0].valid && beats[1].valid) begin
            beats[0] = beats[1];
            beats[1] = '0;
        end
        if (!bus.send_ready) begin
            beats = '0;
        end
        for (int i = 0; i < 2; i++) begin
            if (beats[i].valid) begin
                beats[i].first = !in_pkt;
                in_pkt = !beats[i].last;
                if (!beats[i].last) begin
                    beats[i].bad = 1'b0;
                    beats[i].empty_bytes = '0;
                end
            end else begin
                beats[i] = '0;
            end
        end
        st_d.out = beats;
        st_d.in_packet = in_pkt;
        st_d.ovf = bus.send_overflow;
        st_d.recv.valid = bus.recv_seg3_valid;
        st_d.recv.word = bus.recv_seg3_word;
        st_d.recv.channel = bus.recv_seg3_channel;
        st_d.recv.first = bus.recv_seg3_first;
        st_d.recv.last = bus.recv_seg3_last;
        st_d.recv.bad = bus.recv_seg3_bad;
        st_d.recv.empty_bytes = bus.recv_seg3_empty_bytes;
        st_d.recv.force_burst_word = 1'b0;
        st_d.cfg = i_chan_range_cfg;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_user_ready = bus.send_ready;
    assign o_send_overflow = st_q.ovf;
    assign o_recv_seg = st_q.recv;
    assign bus.send_channel_range_cfg = st_q.cfg;

    assign bus.send_seg0_word = st_q.out[0].word;
    assign bus.send_seg0_channel = st_q.out[0].channel;
    assign bus.send_seg0_valid = st_q.out[0].valid;
    assign bus.send_seg0_first = st_q.out[0].first;
    assign bus.send_seg0_last = st_q.out[0].last;
    assign bus.send_seg0_bad = st_q.out[0].bad;
    assign bus.send_seg0_empty_bytes = st_q.out[0].empty_bytes;
    assign bus.send_seg0_force_burst_word = st_q.out[0].force_burst_word;
    assign bus.send_seg1_word = st_q.out[1].word;
    assign bus.send_seg1_channel = st_q.out[1].channel;
    assign bus.send_seg1_valid = st_q.out[1].valid;
    assign bus.send_seg1_first = st_q.out[1].first;
    assign bus.send_seg1_last = st_q.out[1].last;
    assign bus.send_seg1_bad = st_q.out[1].bad;
    assign bus.send_seg1_empty_bytes = st_q.out[1].empty_bytes;
    assign bus.send_seg1_force_burst_word = st_q.out[1].force_burst_word;

endmodule // send_port_user

`default_nettype wire

// ==== src/send_port_device.sv ====
// device end: send port buffer, back-pressure and receive segment 3
`timescale 1ns/1ps
`default_nettype none
`include "seg_bus_defines.svh"

module send_port_device
    import seg_bus_pkg::*;
#(
    parameter int DEPTH = `SEND_BUF_DEPTH,
    parameter logic [`SEND_COUNT_W-1:0] FILL_THRESH = `SEND_FILL_THRESH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // bus from the user end
    local_segment_bus_if.dev bus,
    // buffered cycles toward the lanes
    output logic o_lane_valid,
    input wire logic i_lane_ready,
    output seg_pair_type o_lane_beats,
    // received segment 3 from the lanes
    input wire seg_type i_recv_seg
);

    typedef struct packed {
        seg_pair_type [DEPTH-1:0] mem;
        logic [$clog2(DEPTH)-1:0] wr_ptr;
        logic [$clog2(DEPTH)-1:0] rd_ptr;
        logic [`SEND_COUNT_W-1:0] count;
        logic ovf;
        seg_type recv;
    } dev_state_type;

    dev_state_type st_q;
    dev_state_type st_d;

    // ---------------------------------------------------------------
    // decoding helpers
    // ---------------------------------------------------------------
    function automatic logic [`SEG_CHAN_W-1:0] chan_limit(
        input logic [`SEG_CFG_W-1:0] cfg
    );
        logic [`SEG_CFG_W-1:0] shift;
        shift = `SEG_CFG_MAX - cfg;
        return `SEG_CHAN_ALL >> shift;
    endfunction

    // sample one send segment, dropping what is not qualified
    function automatic seg_type capture_seg(
        input seg_type raw,
        input logic [`SEG_CFG_W-1:0] cfg
    );
        seg_type s;
        s = '0;
        if (raw.valid) begin
            s.valid = 1'b1;
            s.word = raw.word;
            s.channel = raw.channel & chan_limit(cfg);
            s.first = raw.first;
            s.last = raw.last;
            s.force_burst_word = raw.force_burst_word;
            if (raw.last) begin
                s.bad = raw.bad;
                s.empty_bytes = raw.empty_bytes;
                if (raw.bad) begin
                    s.empty_bytes[`SEG_EMPTY_LOW_W-1:0] = '0;
                end
            end
        end
        return s;
    endfunction

    // ---------------------------------------------------------------
    // segment gathering
    // ---------------------------------------------------------------
    seg_pair_type in_raw;
    seg_pair_type in_seg;

    always_comb begin
        in_raw[0].valid = bus.send_seg0_valid;
        in_raw[0].word = bus.send_seg0_word;
        in_raw[0].channel = bus.send_seg0_channel;
        in_raw[0].first = bus.send_seg0_first;
        in_raw[0].last = bus.send_seg0_last;
        in_raw[0].bad = bus.send_seg0_bad;
        in_raw[0].empty_bytes = bus.send_seg0_empty_bytes;
        in_raw[0].force_burst_word = bus.send_seg0_force_burst_word;
        in_raw[1].valid = bus.send_seg1_valid;
        in_raw[1].word = bus.send_seg1_word;
        in_raw[1].channel = bus.send_seg1_channel;
        in_raw[1].first = bus.send_seg1_first;
        in_raw[1].last = bus.send_seg1_last;
        in_raw[1].bad = bus.send_seg1_bad;
        in_raw[1].empty_bytes = bus.send_seg1_empty_bytes;
        in_raw[1].force_burst_word = bus.send_seg1_force_burst_word;
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_seg
            assign in_seg[g] = capture_seg(in_raw[g],
                bus.send_channel_range_cfg);
        end
    endgenerate

    // ---------------------------------------------------------------
    // buffer and flow control
    // ---------------------------------------------------------------
    logic push;
    logic pop;
    logic full;

    assign push = in_seg[0].valid || in_seg[1].valid;
    assign pop = (st_q.count != '0) && i_lane_ready;
    assign full = st_q.count == `SEND_COUNT_W'(DEPTH);

    always_comb begin
        st_d = st_q;
        st_d.ovf = 1'b0;
        if (pop) begin
            st_d.rd_ptr = st_q.rd_ptr + 1'b1;
        end
        // a full buffer still takes a cycle when one leaves now
        if (push && (!full || pop)) begin
            st_d.mem[st_q.wr_ptr] = in_seg;
            st_d.wr_ptr = st_q.wr_ptr + 1'b1;
        end else if (push) begin
            st_d.ovf = 1'b1;
        end
        if (push && (!full || pop) && !pop) begin
            st_d.count = st_q.count + 1'b1;
        end else if (pop && !(push && (!full || pop))) begin
            st_d.count = st_q.count - 1'b1;
        end
        // receive segment 3 is cleared unless valid
        st_d.recv = '0;
        if (i_recv_seg.valid) begin
            st_d.recv = i_recv_seg;
            st_d.recv.force_burst_word = 1'b0;
            if (!i_recv_seg.last) begin
                st_d.recv.bad = 1'b0;
                st_d.recv.empty_bytes = '0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign bus.send_ready = st_q.count < FILL_THRESH;
    assign bus.send_overflow = st_q.ovf;

    assign o_lane_valid = st_q.count != '0;
    assign o_lane_beats = st_q.mem[st_q.rd_ptr];

    assign bus.recv_seg3_word = st_q.recv.word;
    assign bus.recv_seg3_channel = st_q.recv.channel;
    assign bus.recv_seg3_valid = st_q.recv.valid;
    assign bus.recv_seg3_first = st_q.recv.first;
    assign bus.recv_seg3_last = st_q.recv.last;
    assign bus.recv_seg3_bad = st_q.recv.bad;
    assign bus.recv_seg3_empty_bytes = st_q.recv.empty_bytes;

endmodule // send_port_device

`default_nettype wire

// ==== bench/seg_bus_monitor.sv ====
// assertions on the segment bus between the user end and the device end
`timescale 1ns/1ps
`default_nettype none
`include "seg_bus_defines.svh"

module seg_bus_monitor (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // send segments
    input wire logic [`SEG_WORD_W-1:0] send_seg0_word,
    input wire logic [`SEG_CHAN_W-1:0] send_seg0_channel,
    input wire logic send_seg0_valid,
    input wire logic send_seg0_first,
    input wire logic send_seg0_last,
    input wire logic send_seg1_valid,
    input wire logic send_seg1_first,
    input wire logic send_seg1_last,
    // flow control
    input wire logic send_ready,
    input wire logic send_overflow,
    // receive segment 3
    input wire logic [`SEG_CHAN_W-1:0] recv_seg3_channel,
    input wire logic recv_seg3_valid,
    input wire logic recv_seg3_first,
    input wire logic recv_seg3_last,
    input wire logic recv_seg3_bad,
    input wire logic [`SEG_EMPTY_W-1:0] recv_seg3_empty_bytes
);
    logic open_q;
    logic open_d;
    logic any_valid;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    assign any_valid = send_seg0_valid || send_seg1_valid;

    // packet still open after the last valid segment of a cycle
    always_comb begin
        open_d = open_q;
        if (send_seg1_valid) begin
            open_d = !send_seg1_last;
        end else if (send_seg0_valid) begin
            open_d = !send_seg0_last;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            open_q <= 1'b0;
        end else begin
            open_q <= open_d;
        end
    end

    sequence push_s;
        any_valid && send_ready;
    endsequence

    sequence idle_s;
        !any_valid && send_ready;
    endsequence

    a_reset_ready: assert property (
        $fell(i_sys_rst) |-> send_ready && !send_overflow)
        else $error("ready or overflow wrong after reset");
    a_ready_holds: assert property (idle_s |=> send_ready)
        else $error("ready dropped without a push");
    a_ready_falls: assert property (push_s |=> !send_ready)
        else $error("ready stayed high after a push");
    a_ovf_cause: assert property (
        send_overflow |-> $past(any_valid && !send_ready))
        else $error("overflow without an ignored back-pressure");
    a_user_obeys: assert property (any_valid |-> $past(send_ready))
        else $error("user end sent while ready was low");
    a_idle_zero: assert property (
        !send_seg0_valid |-> send_seg0_word == '0
        && send_seg0_channel == '0 && !send_seg0_first && !send_seg0_last)
        else $error("segment 0 not quiet while invalid");
    a_seg_order: assert property (send_seg1_valid |-> send_seg0_valid)
        else $error("segment 1 used without segment 0");
    a_first_seg0: assert property (
        send_seg0_valid |-> send_seg0_first == !open_q)
        else $error("segment 0 first flag wrong");
    a_first_seg1: assert property (
        send_seg1_valid |-> send_seg1_first
        == (send_seg0_valid ? send_seg0_last : !open_q))
        else $error("segment 1 first flag wrong");
    a_recv_quiet: assert property (
        !recv_seg3_valid |-> {recv_seg3_channel,
        recv_seg3_first, recv_seg3_last, recv_seg3_bad,
        recv_seg3_empty_bytes} == '0)
        else $error("receive qualifiers set while invalid");
endmodule // seg_bus_monitor

`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench: user end and device end back to back
`timescale 1ns/1ps
`default_nettype none
`include "seg_bus_defines.svh"

module tb_top
    import seg_bus_pkg::*;
;
    localparam int PW = $bits(seg_pair_type);
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic lane_ready, lane_valid, lane_valid2, user_ready, ovf, open;
    logic [`SEG_CFG_W-1:0] cfg;
    seg_pair_type beats, lane_beats, lane_beats2, p;
    seg_type recv_in, recv_out, drv2, r;
    seg_pair_type exp_q[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int k;

    local_segment_bus_if bus();
    local_segment_bus_if bus2();

    send_port_user send_port_user_inst (.i_ref_clk, .i_sys_rst,
        .i_user_beats(beats), .i_chan_range_cfg(cfg),
        .o_user_ready(user_ready), .o_send_overflow(ovf),
        .o_recv_seg(recv_out), .bus(bus));
    send_port_device send_port_device_inst (.i_ref_clk, .i_sys_rst,
        .bus(bus), .o_lane_valid(lane_valid), .i_lane_ready(lane_ready),
        .o_lane_beats(lane_beats), .i_recv_seg(recv_in));
    // second device fed directly, to break the back-pressure on purpose
    send_port_device send_port_device_inst2 (.i_ref_clk, .i_sys_rst,
        .bus(bus2), .o_lane_valid(lane_valid2), .i_lane_ready(1'b0),
        .o_lane_beats(lane_beats2), .i_recv_seg(recv_in));
    assign {bus2.send_seg0_valid, bus2.send_seg0_word, bus2.send_seg0_channel,
        bus2.send_seg0_first, bus2.send_seg0_last, bus2.send_seg0_bad,
        bus2.send_seg0_empty_bytes, bus2.send_seg0_force_burst_word} = drv2;
    assign {bus2.send_seg1_valid, bus2.send_seg1_word, bus2.send_seg1_channel,
        bus2.send_seg1_first, bus2.send_seg1_last, bus2.send_seg1_bad,
        bus2.send_seg1_empty_bytes, bus2.send_seg1_force_burst_word} = '0;
    assign bus2.send_channel_range_cfg = `SEG_CFG_MAX;

    seg_bus_monitor seg_bus_monitor_inst (.i_ref_clk, .i_sys_rst,
        .send_seg0_word(bus.send_seg0_word),
        .send_seg0_channel(bus.send_seg0_channel),
        .send_seg0_valid(bus.send_seg0_valid),
        .send_seg0_first(bus.send_seg0_first),
        .send_seg0_last(bus.send_seg0_last),
        .send_seg1_valid(bus.send_seg1_valid),
        .send_seg1_first(bus.send_seg1_first),
        .send_seg1_last(bus.send_seg1_last),
        .send_ready(bus.send_ready), .send_overflow(bus.send_overflow),
        .recv_seg3_channel(bus.recv_seg3_channel),
        .recv_seg3_valid(bus.recv_seg3_valid),
        .recv_seg3_first(bus.recv_seg3_first),
        .recv_seg3_last(bus.recv_seg3_last),
        .recv_seg3_bad(bus.recv_seg3_bad),
        .recv_seg3_empty_bytes(bus.recv_seg3_empty_bytes));

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic check(input logic [PW-1:0] seen, input logic [PW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic hang;
        n_mismatch++;
        tally_and_finish();
    endtask

    // what the device must hand on for one user segment
    function automatic seg_type expect_seg(input seg_type s);
        seg_type e;
        e = '0;
        if (s.valid) begin
            e = s;
            e.first = !open;
            open = !s.last;
            e.channel = s.channel & (`SEG_CHAN_ALL >> (3 - cfg));
            if (!s.last) begin
                e.bad = 1'b0;
                e.empty_bytes = '0;
            end else if (s.bad) begin
                e.empty_bytes[2:0] = 3'h0;
            end
        end
        return e;
    endfunction

    task automatic put(input seg_pair_type b);
        int n;
        seg_pair_type e;
        beats = b;
        for (n = 0; n < 50 && user_ready !== 1'b1; n++) begin
            @(posedge i_ref_clk) #1;
        end
        if (n == 50) hang();
        // a lone segment 1 beat travels in segment 0
        if (!b[0].valid && b[1].valid) begin
            b[0] = b[1];
            b[1] = '0;
        end
        e[0] = expect_seg(b[0]);
        e[1] = expect_seg(b[1]);
        exp_q.push_back(e);
        @(posedge i_ref_clk) #1;
    endtask

    task automatic drain;
        int n;
        for (n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge i_ref_clk) #1;
        if (n == 50) hang();
    endtask

    always @(negedge i_ref_clk) begin
        if (!i_sys_rst && lane_valid === 1'b1 && lane_ready) begin
            if (exp_q.size() == 0) begin
                check(1, 0);
            end else begin
                check(lane_beats, exp_q.pop_front());
            end
        end
    end

    initial begin
        #500000;
        hang();
    end

    initial begin
        beats = '0; cfg = 2'h3; lane_ready = 1'b1; open = 1'b0;
        recv_in = '0; drv2 = '0;
        repeat (6) @(posedge i_ref_clk);
        #1 i_sys_rst = 1'b0;
        check({user_ready, lane_valid, ovf}, 3'h4);
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            cfg = k[1:0];
            repeat (4) @(posedge i_ref_clk) #1;
            p = '0;
            p[0].valid = 1'b1; p[0].word = {4{32'hC0DE0000 + k}};
            p[0].channel = 11'h6AB; p[0].bad = 1'b1;
            p[0].empty_bytes = 4'hF; p[0].force_burst_word = 1'b1;
            p[1] = p[0]; p[1].word = ~p[0].word;
            put(p);
            p[0].last = 1'b1; p[1].last = 1'b1; p[1].bad = 1'b0;
            p[1].empty_bytes = 4'h5; p[1].channel = 11'h155;
            p[1].force_burst_word = 1'b0;
            put(p);
            beats = '0;
            drain();
        end
        $display("test packets done");
        lane_ready = 1'b0;
        p = '0; p[0].valid = 1'b1; p[0].last = 1'b1; p[0].word = 128'hA1;
        put(p);
        p[1] = p[0]; p[1].word = 128'hB2; p[0] = '0;
        put(p);
        beats = '0;
        repeat (3) @(posedge i_ref_clk) #1;
        check({user_ready, lane_valid}, 2'h1);
        check(lane_beats, exp_q[0]);
        lane_ready = 1'b1;
        drain();
        @(posedge i_ref_clk) #1;
        check({user_ready, lane_valid, ovf}, 3'h4);
        $display("test stall done");
        r = '0; r.valid = 1'b1; r.word = 128'h5A5A; r.channel = 11'h3C1;
        r.first = 1'b1; r.last = 1'b1; r.empty_bytes = 4'h7;
        recv_in = r;
        @(posedge i_ref_clk) #1;
        check(bus.recv_seg3_channel, r.channel);
        recv_in = r; recv_in.valid = 1'b0; recv_in.bad = 1'b1;
        @(posedge i_ref_clk) #1;
        check(recv_out, r);
        recv_in = '0;
        @(posedge i_ref_clk) #1;
        check(recv_out, 0);
        $display("test receive done");
        drv2.valid = 1'b1; drv2.last = 1'b1;
        for (k = 0; k < 3; k++) begin
            drv2.word = 128'(k + 1);
            @(posedge i_ref_clk) #1;
            check(bus2.send_overflow, k == 2);
        end
        drv2 = '0;
        @(posedge i_ref_clk) #1;
        check(bus2.send_overflow, 0);
        check(lane_beats2[0].word, 1);
        check(lane_valid2, 1);
        $display("test overflow done");
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
